// ===== common/sfc_defines.svh
// Constants shared by both ends of the serial frame checksum link
`ifndef SFC_DEFINES_SVH
`define SFC_DEFINES_SVH

// Frame lengths in bits
`define SFC_BITS_PLAIN    16
`define SFC_BITS_CHECKED  24
`define SFC_BITS_CRC      8

// Bit counter saturates here so over-long frames never alias to 16 or 24
`define SFC_CNT_MAX       5'h1f

// Checksum: generator x^8 + x^2 + x + 1, zero start value, no inversion
`define SFC_CRC_POLY      8'h07
`define SFC_CRC_INIT      8'h00

// Status register field positions
`define SFC_STAT_VOUT_BIT 0
`define SFC_STAT_IOUT_BIT 1
`define SFC_STAT_TEMP_BIT 2
`define SFC_STAT_CRC_BIT  3
`define SFC_STAT_RESET    4'h0

// Timing: system clock and the serial clock that the host makes
`define SFC_CLK_PERIOD_NS  4
`define SFC_SCLK_PERIOD_NS 128
`define SFC_SCLK_HALF_CYC  ((`SFC_SCLK_PERIOD_NS / `SFC_CLK_PERIOD_NS) / 2)

// Sync-high gap after a frame, in serial half periods
`define SFC_GAP_HALVES     8

`endif

// ===== common/sfc_pkg.sv
// Types and the checksum function for the serial frame checksum link
`include "sfc_defines.svh"
`default_nettype none

package sfc_pkg;

  typedef logic [15:0] sfc_word_t;
  typedef logic [7:0]  sfc_crc_t;

  typedef enum logic [1:0]
  {
    SFC_H_IDLE  = 2'b00,
    SFC_H_SHIFT = 2'b01,
    SFC_H_GAP   = 2'b10
  } sfc_host_state_e;

  // Checksum over a data word, most significant bit first
  function automatic sfc_crc_t sfc_crc8(input sfc_word_t d);
    sfc_crc_t c;
    logic     fb;
    c = `SFC_CRC_INIT;
    for (int i = 15; i >= 0; i--)
    begin
      fb = c[7] ^ d[i];
      c  = {c[6:0], 1'b0} ^ (fb ? `SFC_CRC_POLY : 8'h00);
    end
    return c;
  endfunction

endpackage

`default_nettype wire

// ===== common/sfc_link_if.sv
// Three-wire serial link between the controller and the device
`default_nettype none

interface sfc_link_if;
  logic sclk;
  logic sdi;
  logic sync_n;

  modport host
  (
    output sclk,
    output sdi,
    output sync_n
  );

  modport dev
  (
    input  sclk,
    input  sdi,
    input  sync_n
  );
endinterface

`default_nettype wire

// ===== verilog/sfc_host.sv
// Controller end: serialises data words, optionally with a checksum byte
`include "sfc_defines.svh"
`default_nettype none

module sfc_host
  import sfc_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  sfc_link_if.host         LINK,
  input  wire logic        REQ_VALID,
  input  wire logic [15:0] REQ_WORD,
  input  wire logic        REQ_CHECK,
  output logic             REQ_READY
);

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock divider
  logic [4:0]      half_cnt;
  logic            tick;
  sfc_host_state_e state;
  sfc_host_state_e next_state;
  logic [23:0]     frame;
  logic [4:0]      bit_idx;
  logic [4:0]      n_bits;
  logic            sclk;
  logic            sdi;
  logic            sync_n;
  logic            take;
  logic            last_bit;
  logic [23:0]     next_frame;

  assign tick = (half_cnt == 5'(`SFC_SCLK_HALF_CYC - 1));

  always_ff @(posedge CLK or negedge ARST_N)
    if (!ARST_N)
      half_cnt <= 5'h00;
    else if (tick || state == SFC_H_IDLE)
      half_cnt <= 5'h00;
    else
      half_cnt <= half_cnt + 5'h01;

  ////////////////////////////////////////////////////////////////////////////
  // Frame build and sequencing
  assign take       = REQ_VALID && REQ_READY;
  assign last_bit   = (bit_idx + 5'h01 == n_bits);
  // Checksum byte follows the data word
  assign next_frame = REQ_CHECK ? {REQ_WORD, sfc_crc8(REQ_WORD)}
                                : {REQ_WORD, 8'h00};

  always_comb
  begin
    next_state = state;
    case (state)
      SFC_H_IDLE:
        if (take)
          next_state = SFC_H_SHIFT;
      SFC_H_SHIFT:
        if (tick && !sclk && last_bit)
          next_state = SFC_H_GAP;
      SFC_H_GAP:
        if (tick && bit_idx == 5'(`SFC_GAP_HALVES - 1))
          next_state = SFC_H_IDLE;
      default:
        next_state = SFC_H_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N)
    if (!ARST_N)
      state <= SFC_H_IDLE;
    else
      state <= next_state;

  // Data changes after a rising edge, device samples on the falling one
  always_ff @(posedge CLK or negedge ARST_N)
    if (!ARST_N)
    begin
      frame   <= 24'h000000;
      bit_idx <= 5'h00;
      n_bits  <= 5'h00;
      sclk    <= 1'b1;
      sdi     <= 1'b0;
      sync_n  <= 1'b1;
    end
    else if (state == SFC_H_IDLE)
    begin
      sclk <= 1'b1;
      if (take)
      begin
        frame   <= next_frame;
        sdi     <= next_frame[23];
        bit_idx <= 5'h00;
        // Exactly 24 bits for a checked frame, else 16
        n_bits  <= REQ_CHECK ? 5'(`SFC_BITS_CHECKED) : 5'(`SFC_BITS_PLAIN);
        sync_n  <= 1'b0;
      end
    end
    else if (state == SFC_H_SHIFT && tick)
    begin
      sclk <= ~sclk;
      if (!sclk)
      begin
        if (last_bit)
        begin
          sync_n  <= 1'b1;
          bit_idx <= 5'h00;
        end
        else
        begin
          frame   <= {frame[22:0], 1'b0};
          sdi     <= frame[22];
          bit_idx <= bit_idx + 5'h01;
        end
      end
    end
    else if (state == SFC_H_GAP && tick)
      bit_idx <= bit_idx + 5'h01;

  always_ff @(posedge CLK or negedge ARST_N)
    if (!ARST_N)
      REQ_READY <= 1'b0;
    else
      REQ_READY <= (next_state == SFC_H_IDLE) && !take;

  // Only three wires leave this end
  assign LINK.sclk   = sclk;
  assign LINK.sdi    = sdi;
  assign LINK.sync_n = sync_n;

endmodule

`default_nettype wire

// ===== verilog/sfc_device.sv
// Device end: shifts in frames, checks the checksum, commits or flags
`include "sfc_defines.svh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Controller appends CRC-8 over data word
// - Checked frame is exactly 24 bits
// - Check 24-bit frame when sync rises
// - Write 16-bit frame, or 24-bit one if checksum matches
// - Failure pulls fault low, sets D3
// - Status read clears flag, releases fault
// - Data sampled on falling serial clock
// - Link uses clock, data, sync only
// - D3 is checksum error only
// - Fault output shared with other faults
module sfc_device
  import sfc_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  sfc_link_if.dev          LINK,
  input  wire logic [2:0]  OTHER_FAULT,
  input  wire logic        STATUS_RD,
  output logic             WR_STB,
  output logic [15:0]      WR_WORD,
  output logic             DROP_STB,
  output logic [3:0]       STATUS,
  output logic             FAULT_N_O,
  output logic             FAULT_N_OE
);

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: runs only on serial clock edges inside a frame
  logic [23:0] shift;
  logic [4:0]  bit_cnt;
  logic        link_clr;

  // Cleared from the system side between frames, so no edge is needed
  // after sync rises
  always_ff @(negedge LINK.sclk or posedge link_clr)
    if (link_clr)
    begin
      shift   <= 24'h000000;
      bit_cnt <= 5'h00;
    end
    else if (!LINK.sync_n)
    begin
      shift <= {shift[22:0], LINK.sdi};
      if (bit_cnt != `SFC_CNT_MAX)
        bit_cnt <= bit_cnt + 5'h01;
    end

  ////////////////////////////////////////////////////////////////////////////
  // Sync crossing into the system clock
  logic sync_meta;
  logic sync_s;
  logic sync_d;
  logic sync_rise;

  always_ff @(posedge CLK or negedge ARST_N)
    if (!ARST_N)
    begin
      sync_meta <= 1'b1;
      sync_s    <= 1'b1;
      sync_d    <= 1'b1;
    end
    else
    begin
      sync_meta <= LINK.sync_n;
      sync_s    <= sync_meta;
      sync_d    <= sync_s;
    end

  assign sync_rise = sync_s && !sync_d;

  // Link-side counters are released once sync is seen low again; the
  // shift word holds while sync is high until the clear zeroes it, because shifting is gated on sync low
  logic next_link_clr;

  assign next_link_clr = sync_rise ? 1'b1 :
                         !sync_s   ? 1'b0 : link_clr;

  always_ff @(posedge CLK or negedge ARST_N)
    if (!ARST_N)
      link_clr <= 1'b1;
    else
      link_clr <= next_link_clr;

  ////////////////////////////////////////////////////////////////////////////
  // Frame evaluation at the end of a frame
  logic      is_plain;
  logic      is_checked;
  logic      crc_ok;
  logic      do_write;
  logic      crc_fail;
  logic      do_drop;
  sfc_word_t next_word;

  assign is_plain   = sync_rise && bit_cnt == 5'(`SFC_BITS_PLAIN);
  assign is_checked = sync_rise && bit_cnt == 5'(`SFC_BITS_CHECKED);
  // Received byte must equal the checksum of the received word
  assign crc_ok     = (sfc_crc8(shift[23:8]) == shift[7:0]);
  assign do_write   = is_plain || (is_checked && crc_ok);
  assign crc_fail   = is_checked && !crc_ok;
  assign do_drop    = sync_rise && !is_plain && !is_checked;
  assign next_word  = is_plain ? shift[15:0] : shift[23:8];

  always_ff @(posedge CLK or negedge ARST_N)
    if (!ARST_N)
    begin
      WR_STB   <= 1'b0;
      WR_WORD  <= 16'h0000;
      DROP_STB <= 1'b0;
    end
    else
    begin
      WR_STB   <= do_write;
      DROP_STB <= do_drop;
      if (do_write)
        WR_WORD <= next_word;
    end

  ////////////////////////////////////////////////////////////////////////////
  // Status register and fault output
  logic       crc_flag;
  logic       next_crc_flag;
  logic [3:0] next_status;
  logic       fault_any;

  // A failure in the cycle of a read survives the clear
  assign next_crc_flag = crc_fail || (crc_flag && !STATUS_RD);

  // D3 carries only the checksum error, beside the other fault bits
  assign next_status = {crc_flag || crc_fail,
                        OTHER_FAULT[`SFC_STAT_TEMP_BIT],
                        OTHER_FAULT[`SFC_STAT_IOUT_BIT],
                        OTHER_FAULT[`SFC_STAT_VOUT_BIT]};

  assign fault_any = next_crc_flag || (|OTHER_FAULT);

  always_ff @(posedge CLK or negedge ARST_N)
    if (!ARST_N)
    begin
      crc_flag   <= 1'b0;
      STATUS     <= `SFC_STAT_RESET;
      FAULT_N_O  <= 1'b0;
      FAULT_N_OE <= 1'b0;
    end
    else
    begin
      crc_flag   <= next_crc_flag;
      FAULT_N_O  <= 1'b0;
      FAULT_N_OE <= fault_any;
      if (STATUS_RD)
        STATUS <= next_status;
    end

endmodule

`default_nettype wire

// ===== testbench/sfc_link_chk.sv
// Assertions on the link between controller and device
`default_nettype none

module sfc_link_chk
(
  input wire logic       CLK,
  input wire logic       ARST_N,
  input wire logic       sclk,
  input wire logic       sdi,
  input wire logic       sync_n,
  input wire logic       REQ_VALID,
  input wire logic       REQ_READY,
  input wire logic       WR_STB,
  input wire logic       DROP_STB,
  input wire logic [3:0] STATUS,
  input wire logic [2:0] OTHER_FAULT,
  input wire logic       FAULT_N_OE
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  sequence s_end;
    $rose(sync_n);
  endsequence

  sequence s_take;
    REQ_VALID && REQ_READY;
  endsequence

  a_commit_after_end: assert property (s_end |-> ##[2:6] WR_STB)
    else $error("no write after frame end");
  a_write_pulse: assert property (WR_STB |=> !WR_STB)
    else $error("write strobe too long");
  a_no_drop: assert property (!DROP_STB)
    else $error("host frame dropped");
  a_no_crc_flag: assert property (!STATUS[3])
    else $error("checksum flag on good frames");
  a_sclk_idle_high: assert property (sync_n |-> sclk)
    else $error("serial clock low outside frame");
  a_sdi_held: assert property ($fell(sclk) |-> $stable(sdi) && !sync_n)
    else $error("data moved at sampling edge");
  a_ready_low_frame: assert property (!sync_n |-> !REQ_READY)
    else $error("ready during frame");
  a_take_starts: assert property (s_take |=> !sync_n)
    else $error("frame did not start");
  a_fault_other: assert property ($rose(|OTHER_FAULT) |-> ##[1:4] FAULT_N_OE)
    else $error("fault pin not pulled");
endmodule

`default_nettype wire

// ===== testbench/tb.sv
// Testbench joining controller and device, plus a raw driver on a second link
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 0;
  logic        arst_n = 0;
  logic        rv = 0;
  logic        rc = 0;
  logic        rd = 0;
  logic        rd2 = 0;
  logic [15:0] rw = '0;
  logic [15:0] w;
  logic [2:0]  of = '0;
  logic [2:0]  of2 = '0;
  logic        rdy, wr, drop, fo, foe, wr2, drop2, fo2, foe2;
  logic [15:0] ww, ww2;
  logic [3:0]  st, st2;
  logic [31:0] lf = 32'hde371e28;
  int          num_errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          nwr = 0;
  int          ndrop = 0;
  int          lens[4] = '{15, 17, 23, 25};

  sfc_link_if lk();
  sfc_link_if lk2();

  sfc_host u_sfc_host (.CLK(clk), .ARST_N(arst_n), .LINK(lk.host),
    .REQ_VALID(rv), .REQ_WORD(rw), .REQ_CHECK(rc), .REQ_READY(rdy));
  sfc_device u_sfc_device (.CLK(clk), .ARST_N(arst_n), .LINK(lk.dev),
    .OTHER_FAULT(of), .STATUS_RD(rd), .WR_STB(wr), .WR_WORD(ww),
    .DROP_STB(drop), .STATUS(st), .FAULT_N_O(fo), .FAULT_N_OE(foe));
  sfc_device u_sfc_device_b (.CLK(clk), .ARST_N(arst_n), .LINK(lk2.dev),
    .OTHER_FAULT(of2), .STATUS_RD(rd2), .WR_STB(wr2), .WR_WORD(ww2),
    .DROP_STB(drop2), .STATUS(st2), .FAULT_N_O(fo2), .FAULT_N_OE(foe2));
  sfc_link_chk u_sfc_link_chk (.CLK(clk), .ARST_N(arst_n), .sclk(lk.sclk),
    .sdi(lk.sdi), .sync_n(lk.sync_n), .REQ_VALID(rv), .REQ_READY(rdy),
    .WR_STB(wr), .DROP_STB(drop), .STATUS(st), .OTHER_FAULT(of),
    .FAULT_N_OE(foe));

  ////////////////////////////////////////////////////////////////////////////
  always #2 clk = ~clk;

  always @(posedge clk)
  begin
    cyc++;
    nwr += int'(wr2);
    ndrop += int'(drop2);
    if (cyc == 40000)
    begin
      num_errors++;
      stop_test();
    end
  end

  function automatic logic [7:0] crc(input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic check(input string n, input logic [15:0] s, e);
    num_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic send(input logic [15:0] d, input logic c);
    int n;
    n = 0;
    @(negedge clk);
    while (rdy !== 1'b1 && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    rv = 1;
    rw = d;
    rc = c;
    @(negedge clk);
    rv = 0;
    n = 0;
    while (wr !== 1'b1 && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    check("wr", 16'(wr), 16'h0001);
    check("word", ww, d);
  endtask

  // Raw frame on the second link; data is inverted once sync rises
  task automatic frame(input logic [31:0] b, input int n, ew, ed);
    int w0, d0;
    w0 = nwr;
    d0 = ndrop;
    lk2.sync_n = 0;
    #40;
    for (int i = n - 1; i >= 0; i--)
    begin
      lk2.sdi = b[i];
      #31.5 lk2.sclk = 0;
      #62.5 lk2.sclk = 1;
      #31;
    end
    lk2.sync_n = 1;
    lk2.sdi = ~lk2.sdi;
    #200;
    check("wr2", 16'(nwr - w0), 16'(ew));
    check("drop2", 16'(ndrop - d0), 16'(ed));
  endtask

  task automatic read(input bit b);
    @(negedge clk);
    rd = !b;
    rd2 = b;
    @(negedge clk);
    rd = 0;
    rd2 = 0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    lk2.sclk = 1;
    lk2.sdi = 0;
    lk2.sync_n = 1;
    repeat (3) @(negedge clk);
    arst_n = 1;
    send(16'h0000, 1'b1);
    send(16'hffff, 1'b0);
    repeat (12)
    begin
      lf = nxt(lf);
      send(lf[15:0], lf[16]);
    end
    w = lf[31:16];
    frame({8'h00, w, crc(w)}, 24, 1, 0);
    check("ww2", ww2, w);
    frame({8'h00, w, crc(w) ^ 8'h01}, 24, 0, 0);
    check("foe2", 16'(foe2), 16'h0001);
    check("fo2", 16'(fo2), 16'h0000);
    read(1);
    check("st2", 16'(st2), 16'h0008);
    check("foe2", 16'(foe2), 16'h0000);
    read(1);
    check("st2", 16'(st2), 16'h0000);
    frame({16'h0000, ~w}, 16, 1, 0);
    check("ww2", ww2, ~w);
    foreach (lens[i])
      frame(nxt(lf), lens[i], 0, 1);
    @(negedge clk);
    of2 = 3'b010;
    read(1);
    check("st2", 16'(st2), 16'h0002);
    check("foe2", 16'(foe2), 16'h0001);
    of = 3'b100;
    read(0);
    repeat (4) @(negedge clk);
    check("st", 16'(st), 16'h0004);
    check("foe", 16'(foe), 16'h0001);
    check("fo", 16'(fo), 16'h0000);
    of = 3'b000;
    of2 = 3'b000;
    stop_test();
  end
endmodule

`default_nettype wire
